// file: hw/awss_top.sv
`timescale 1ns/1ps
`include "awss_params.svh"

// Overview of operation
// [RL1] Bit 1 of the event status byte is set on every wake-to-sleep or sleep-to-wake move and stays set until cleared.
// [RL2] Sleep is entered once no configured event has occurred for the programmed inactivity count of ODR periods.
// [RL3] On entering sleep the sleep power setting and sleep rate, or sleep decimation and idle time, are applied.
// [RL4] While asleep the device wakes as soon as any configured event flag becomes active.
// [RL5] On waking the wake power setting and wake rate, or wake decimation and idle time, are applied.
// [RL6] The system state register reports the present state so the host sees the latest transition direction.
// [RL7] Any host read of the system state register clears the mode-change flag.
// [RL8] Auto wake/sleep and its flag work only when the inactivity count is 1 or more; zero disables both.
// [RL9] The mode-change flag operates only while its interrupt enable bit is 1.
// [RL10] The boot-done flag, bit 0 of the event status byte, reads 0 while boot is still running.
// [RL11] The boot-done flag sets when boot finishes and stays set until power-on reset, soft reset or hibernate exit.
// [RL12] The event status byte sits at register address 00h.
// [RL13] While awake any configured event restarts the inactivity count so sleep needs an unbroken idle span.

module awss_top (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // host register port
  input wire awss_pkg::awss_req_t regReq,
  output logic [7:0] regReadData,
  output logic regReadValid,
  // sensor side
  input wire logic odrTick,
  input wire logic eventActive,
  input wire logic bootFinished,
  input wire logic softReset,
  input wire logic hibernateExit,
  // applied power state
  output awss_pkg::awss_power_t activePower,
  output logic asleep
);

  awss_pkg::awss_state_t state;
  awss_pkg::awss_state_t next_state;
  logic [15:0] inactivityCount;
  logic autoEnabled;
  logic idleExpired;
  logic counterRestart;
  logic toSleep;
  logic toWake;
  logic transition;
  logic readStateReg;

  function automatic logic hits(input awss_pkg::awss_req_t req, input logic [7:0] addr);
    hits = req.addr == addr;
  endfunction

  function automatic awss_pkg::awss_power_t settingsFor(input logic sleeping, input awss_pkg::awss_state_t s);
    awss_pkg::awss_power_t p;
    p.flex = s.perfSelect[`AWSS_BIT_FLEX_SEL];
    if (sleeping) begin
      p.power = s.sensorSetupB[`AWSS_BIT_SLEEP_POWER];
      p.rate = s.rateSelect[7:4];
      p.decim = s.flexSleep[3:0];
      p.idle = s.flexSleep[7:4];
    end else begin
      p.power = s.sensorSetupB[`AWSS_BIT_WAKE_POWER];
      p.rate = s.rateSelect[3:0];
      p.decim = s.flexWake[3:0];
      p.idle = s.flexWake[7:4];
    end
    // only the pair that flex selects is carried; flex zeroes rate, otherwise decim and idle are zeroed
    if (p.flex) begin
      p.rate = 4'h0;
    end else begin
      p.decim = 4'h0;
      p.idle = 4'h0;
    end
    settingsFor = p;
  endfunction

  assign inactivityCount = {state.inactivityCountHigh, state.inactivityCountLow};
  assign autoEnabled = inactivityCount != `AWSS_RST_COUNT; // [RL8]

  // asleep or booting holds the idle count at zero
  assign counterRestart = eventActive || state.mode != awss_pkg::AWSS_WAKE; // [RL13]

  awss_idle_counter idleCounter (
    .clock(clock),
    .rst(rst),
    .odrTick(odrTick),
    .restart(counterRestart),
    .limit(inactivityCount),
    .expired(idleExpired)
  );

  assign toSleep = state.mode == awss_pkg::AWSS_WAKE && autoEnabled && idleExpired && !eventActive; // [RL2]
  // a zero count while asleep also returns to wake, since the function is off
  assign toWake = state.mode == awss_pkg::AWSS_SLEEP && (eventActive || !autoEnabled); // [RL4] [RL8]
  assign transition = toSleep || toWake;
  assign readStateReg = regReq.rd && state.bootDoneFlag && hits(regReq, `AWSS_ADDR_SYSTEM_STATE);

  always_comb begin
    next_state = state;
    next_state.readValid = 1'b0;

    case (state.mode)
      awss_pkg::AWSS_BOOTING: begin
        if (bootFinished) begin
          next_state.mode = awss_pkg::AWSS_WAKE;
        end
      end
      awss_pkg::AWSS_WAKE: begin
        if (toSleep) begin
          next_state.mode = awss_pkg::AWSS_SLEEP; // [RL2]
        end
      end
      awss_pkg::AWSS_SLEEP: begin
        if (toWake) begin
          next_state.mode = awss_pkg::AWSS_WAKE; // [RL4]
        end
      end
      default: begin
        next_state.mode = awss_pkg::AWSS_BOOTING;
      end
    endcase

    if (bootFinished && state.mode == awss_pkg::AWSS_BOOTING) begin
      next_state.bootDoneFlag = 1'b1; // [RL11]
    end

    // clear on read first so a same-cycle transition still sets the flag
    if (readStateReg) begin
      next_state.modeChangeFlag = 1'b0; // [RL7]
    end
    if (!autoEnabled || !state.irqEnable[`AWSS_BIT_MODE_IRQ_EN]) begin
      next_state.modeChangeFlag = 1'b0; // [RL8] [RL9]
    end else if (transition) begin
      next_state.modeChangeFlag = 1'b1; // [RL1]
    end

    // soft reset or hibernate exit restart boot; register contents stay as written
    // placed last so a same-cycle boot finish cannot leave the boot flag set while booting
    if (softReset || hibernateExit) begin
      next_state.mode = awss_pkg::AWSS_BOOTING;
      next_state.bootDoneFlag = 1'b0; // [RL11]
      next_state.modeChangeFlag = 1'b0;
    end

    next_state.active = settingsFor(next_state.mode == awss_pkg::AWSS_SLEEP, state); // [RL3] [RL5]

    // writes are ignored and reads return zero until boot completes, so the boot flag reads 0 while booting
    if (regReq.wr && state.bootDoneFlag) begin
      case (regReq.addr)
        `AWSS_ADDR_IRQ_ENABLE: next_state.irqEnable = regReq.wdata;
        `AWSS_ADDR_SENSOR_SETUP_B: next_state.sensorSetupB = regReq.wdata;
        `AWSS_ADDR_RATE_SELECT: next_state.rateSelect = regReq.wdata;
        `AWSS_ADDR_FLEX_WAKE: next_state.flexWake = regReq.wdata;
        `AWSS_ADDR_FLEX_SLEEP: next_state.flexSleep = regReq.wdata;
        `AWSS_ADDR_PERF_SELECT: next_state.perfSelect = regReq.wdata;
        `AWSS_ADDR_INACT_LOW: next_state.inactivityCountLow = regReq.wdata;
        `AWSS_ADDR_INACT_HIGH: next_state.inactivityCountHigh = regReq.wdata;
        default: begin
        end
      endcase
    end

    if (regReq.rd) begin
      next_state.readValid = 1'b1;
      next_state.readData = `AWSS_RST_BYTE;
      if (state.bootDoneFlag) begin
        case (regReq.addr)
          `AWSS_ADDR_EVENT_STATUS: begin
            next_state.readData[`AWSS_BIT_MODE_CHANGE] = state.modeChangeFlag; // [RL1] [RL12]
            next_state.readData[`AWSS_BIT_BOOT_DONE] = state.bootDoneFlag; // [RL10]
          end
          `AWSS_ADDR_SYSTEM_STATE: begin
            next_state.readData[`AWSS_BIT_SLEEPING] = state.mode == awss_pkg::AWSS_SLEEP; // [RL6]
          end
          `AWSS_ADDR_IRQ_ENABLE: next_state.readData = state.irqEnable;
          `AWSS_ADDR_SENSOR_SETUP_B: next_state.readData = state.sensorSetupB;
          `AWSS_ADDR_RATE_SELECT: next_state.readData = state.rateSelect;
          `AWSS_ADDR_FLEX_WAKE: next_state.readData = state.flexWake;
          `AWSS_ADDR_FLEX_SLEEP: next_state.readData = state.flexSleep;
          `AWSS_ADDR_PERF_SELECT: next_state.readData = state.perfSelect;
          `AWSS_ADDR_INACT_LOW: next_state.readData = state.inactivityCountLow;
          `AWSS_ADDR_INACT_HIGH: next_state.readData = state.inactivityCountHigh;
          default: next_state.readData = `AWSS_RST_BYTE;
        endcase
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state.mode <= awss_pkg::AWSS_BOOTING;
      state.modeChangeFlag <= 1'b0;
      state.bootDoneFlag <= 1'b0; // [RL10]
      state.irqEnable <= `AWSS_RST_IRQ_ENABLE;
      state.sensorSetupB <= `AWSS_RST_SENSOR_SETUP_B;
      state.rateSelect <= `AWSS_RST_RATE_SELECT;
      state.flexWake <= `AWSS_RST_FLEX;
      state.flexSleep <= `AWSS_RST_FLEX;
      state.perfSelect <= `AWSS_RST_PERF_SELECT;
      state.inactivityCountLow <= `AWSS_RST_BYTE;
      state.inactivityCountHigh <= `AWSS_RST_BYTE;
      state.readData <= `AWSS_RST_BYTE;
      state.readValid <= 1'b0;
      state.active <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign regReadData = state.readData;
  assign regReadValid = state.readValid;
  assign activePower = state.active;
  assign asleep = state.mode == awss_pkg::AWSS_SLEEP;

endmodule

// file: hw/awss_params.svh
`ifndef AWSS_PARAMS_SVH
`define AWSS_PARAMS_SVH

// register addresses
`define AWSS_ADDR_EVENT_STATUS 8'h00
`define AWSS_ADDR_SYSTEM_STATE 8'h14
`define AWSS_ADDR_IRQ_ENABLE 8'h15
`define AWSS_ADDR_SENSOR_SETUP_B 8'h16
`define AWSS_ADDR_RATE_SELECT 8'h17
`define AWSS_ADDR_FLEX_WAKE 8'h18
`define AWSS_ADDR_FLEX_SLEEP 8'h19
`define AWSS_ADDR_PERF_SELECT 8'h1A
`define AWSS_ADDR_INACT_LOW 8'h1B
`define AWSS_ADDR_INACT_HIGH 8'h1C

// field positions
`define AWSS_BIT_BOOT_DONE 0
`define AWSS_BIT_MODE_CHANGE 1
`define AWSS_BIT_SLEEPING 0
`define AWSS_BIT_MODE_IRQ_EN 1
`define AWSS_BIT_WAKE_POWER 0
`define AWSS_BIT_SLEEP_POWER 1
`define AWSS_BIT_FLEX_SEL 0

// reset values
`define AWSS_RST_BYTE 8'h00
`define AWSS_RST_COUNT 16'h0000
`define AWSS_RST_IRQ_ENABLE 8'h00
`define AWSS_RST_SENSOR_SETUP_B 8'h00
`define AWSS_RST_RATE_SELECT 8'h00
`define AWSS_RST_FLEX 8'h00
`define AWSS_RST_PERF_SELECT 8'h00

`endif

// file: hw/awss_pkg.sv
package awss_pkg;

  // gray along booting -> wake -> sleep
  typedef enum logic [1:0] {
    AWSS_BOOTING = 2'h0,
    AWSS_WAKE = 2'h1,
    AWSS_SLEEP = 2'h3
  } awss_mode_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } awss_req_t;

  typedef struct packed {
    logic power;
    logic flex;
    logic [3:0] rate;
    logic [3:0] decim;
    logic [3:0] idle;
  } awss_power_t;

  typedef struct packed {
    logic [15:0] count;
    logic expired;
  } awss_cnt_state_t;

  typedef struct packed {
    awss_mode_t mode;
    logic modeChangeFlag;
    logic bootDoneFlag;
    logic [7:0] irqEnable;
    logic [7:0] sensorSetupB;
    logic [7:0] rateSelect;
    logic [7:0] flexWake;
    logic [7:0] flexSleep;
    logic [7:0] perfSelect;
    logic [7:0] inactivityCountLow;
    logic [7:0] inactivityCountHigh;
    logic [7:0] readData;
    logic readValid;
    awss_power_t active;
  } awss_state_t;

endpackage

// file: hw/awss_idle_counter.sv
`timescale 1ns/1ps
`include "awss_params.svh"

module awss_idle_counter (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic odrTick,
  input wire logic restart,
  input wire logic [15:0] limit,
  // result
  output logic expired
);

  awss_pkg::awss_cnt_state_t state;
  awss_pkg::awss_cnt_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.expired = 1'b0;
    if (restart || limit == `AWSS_RST_COUNT) begin
      next_state.count = `AWSS_RST_COUNT; // [RL13]
    end else if (odrTick) begin
      // compare before incrementing so a full-scale limit cannot wrap
      if (state.count + 16'h0001 >= limit) begin
        next_state.expired = 1'b1; // [RL2]
        next_state.count = `AWSS_RST_COUNT;
      end else begin
        next_state.count = state.count + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign expired = state.expired;

endmodule

// file: testbench/awss_properties.sv
`timescale 1ns/1ps
`include "awss_params.svh"
module awss_properties (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // host port
  input wire awss_pkg::awss_req_t regReq,
  input wire logic [7:0] regReadData,
  input wire logic regReadValid,
  // sensor side
  input wire logic odrTick,
  input wire logic eventActive,
  input wire logic bootFinished,
  input wire logic softReset,
  input wire logic hibernateExit,
  input wire awss_pkg::awss_power_t activePower,
  input wire logic asleep
);
  logic booting;
  logic next_booting;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // a restart and a finish never meet in one cycle, so restart simply wins
  always_comb next_booting = (softReset || hibernateExit) ? 1'b1 : (bootFinished ? 1'b0 : booting);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) booting <= 1'b1;
    else booting <= next_booting;
  end
  sequence rdState; regReq.rd && regReq.addr == `AWSS_ADDR_SYSTEM_STATE; endsequence
  sequence rdStatus; regReq.rd && regReq.addr == `AWSS_ADDR_EVENT_STATUS; endsequence
  a_wake_on_event: assert property (asleep && eventActive |=> !asleep)
    else $error("event did not wake");
  a_sleep_after_tick: assert property ($rose(asleep) |-> $past(odrTick, 2) && !$past(eventActive, 2))
    else $error("sleep without idle tick");
  a_power_follows_mode: assert property (!$stable(activePower) |-> !$stable(asleep) || $past(regReq.wr)
    || $past(regReq.wr, 2) || $past(bootFinished) || $past(softReset || hibernateExit))
    else $error("power changed without cause");
  a_state_readback: assert property (rdState |=> regReadData[`AWSS_BIT_SLEEPING] == $past(asleep))
    else $error("state read wrong");
  a_boot_reads_zero: assert property (booting && regReq.rd |=> regReadData == 8'h00)
    else $error("read during boot not zero");
  a_boot_flag_set: assert property ((!booting and rdStatus) |=> regReadData[`AWSS_BIT_BOOT_DONE])
    else $error("boot flag missing");
  a_status_upper_zero: assert property (rdStatus |=> regReadData[7:2] == 6'h00)
    else $error("status upper bits set");
  // the host leaves one idle cycle between reads; a mode move in that gap would set the flag again
  a_read_clears_flag: assert property (rdState ##1 $stable(asleep) ##1 (rdStatus and $stable(asleep))
    |=> !regReadData[1])
    else $error("flag not cleared by state read");
  a_read_answer: assert property (regReq.rd |=> regReadValid)
    else $error("read got no answer");
endmodule
bind awss_top awss_properties chk_u (.clock(clock), .rst(rst), .regReq(regReq), .regReadData(regReadData),
  .regReadValid(regReadValid), .odrTick(odrTick), .eventActive(eventActive), .bootFinished(bootFinished),
  .softReset(softReset), .hibernateExit(hibernateExit), .activePower(activePower), .asleep(asleep));

// file: testbench/awss_host.sv
`timescale 1ns/1ps
module awss_host (
  // clock
  input wire logic clock,
  // register port
  output awss_pkg::awss_req_t regReq,
  input wire logic [7:0] regReadData,
  input wire logic regReadValid
);
  initial regReq = '0;
  // a released bus shows inverted address and data, never a stale copy
  task automatic release_bus();
    regReq.rd = 1'b0;
    regReq.wr = 1'b0;
    regReq.addr = ~regReq.addr;
    regReq.wdata = ~regReq.wdata;
  endtask
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clock);
    regReq = '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
    @(negedge clock);
    release_bus();
  endtask
  task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    @(negedge clock);
    regReq = '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 8'h00};
    @(negedge clock);
    release_bus();
    ok = 1'b0;
    data = 8'h00;
    for (int i = 0; i < 3 && !ok; i++) begin
      if (regReadValid === 1'b1) begin
        data = regReadData;
        ok = 1'b1;
      end else @(negedge clock);
    end
  endtask
endmodule

// file: testbench/auto_wake_sleep_status_tb.sv
`timescale 1ns/1ps
`include "awss_params.svh"
module auto_wake_sleep_status_tb;
  logic clock;
  logic rst;
  awss_pkg::awss_req_t regReq;
  logic [7:0] regReadData;
  logic regReadValid;
  logic odrTick;
  logic eventActive;
  logic bootFinished;
  logic softReset;
  logic hibernateExit;
  awss_pkg::awss_power_t activePower;
  logic asleep;
  logic [7:0] rdata;
  logic ok;
  logic [13:0] sleepExp;
  logic [13:0] wakeExp;
  int err_total;
  int num_checks;
  awss_top dut_u (.clock(clock), .rst(rst), .regReq(regReq), .regReadData(regReadData),
    .regReadValid(regReadValid), .odrTick(odrTick), .eventActive(eventActive), .bootFinished(bootFinished),
    .softReset(softReset), .hibernateExit(hibernateExit), .activePower(activePower), .asleep(asleep));
  awss_host host_u (.clock(clock), .regReq(regReq), .regReadData(regReadData), .regReadValid(regReadValid));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp, input string what);
    host_u.rd(addr, rdata, ok);
    if (ok !== 1'b1) begin
      err_total++;
      $display("Error %s expected answer seen none", what);
      close_out();
    end else begin
      check(what, {8'h00, exp}, {8'h00, rdata});
    end
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge clock);
      odrTick = 1'b1;
      @(negedge clock);
      odrTick = 1'b0;
    end
    repeat (2) @(negedge clock);
  endtask
  task automatic boot();
    @(negedge clock);
    bootFinished = 1'b1;
    @(negedge clock);
    bootFinished = 1'b0;
  endtask
  task automatic set_event(input logic v);
    @(negedge clock);
    eventActive = v;
    repeat (2) @(negedge clock);
  endtask
  initial begin
    rst = 1'b1;
    odrTick = 1'b0;
    eventActive = 1'b0;
    bootFinished = 1'b0;
    softReset = 1'b0;
    hibernateExit = 1'b0;
    err_total = 0;
    num_checks = 0;
    repeat (3) @(negedge clock);
    rst = 1'b0;
    rdchk(`AWSS_ADDR_EVENT_STATUS, 8'h00, "status booting");
    boot();
    rdchk(`AWSS_ADDR_EVENT_STATUS, 8'h01, "status booted");
    rdchk(8'h30, 8'h00, "unmapped");
    $display("test boot done");
    host_u.wr(`AWSS_ADDR_SENSOR_SETUP_B, 8'h02);
    host_u.wr(`AWSS_ADDR_RATE_SELECT, 8'h5A);
    host_u.wr(`AWSS_ADDR_FLEX_WAKE, 8'h21);
    host_u.wr(`AWSS_ADDR_FLEX_SLEEP, 8'h43);
    host_u.wr(`AWSS_ADDR_INACT_LOW, 8'h03);
    host_u.wr(`AWSS_ADDR_IRQ_ENABLE, 8'h02);
    for (int f = 0; f < 2; f++) begin
      // {power, flex, rate, decim, idle}
      sleepExp = (f == 1) ? 14'h3034 : 14'h2500;
      wakeExp = (f == 1) ? 14'h1012 : 14'h0A00;
      host_u.wr(`AWSS_ADDR_PERF_SELECT, 8'(f));
      tick(2);
      set_event(1'b1);
      set_event(1'b0);
      tick(2);
      check("awake after restart", 16'h0000, {15'h0000, asleep});
      tick(1);
      check("asleep", 16'h0001, {15'h0000, asleep});
      check("sleep power", {2'b00, sleepExp}, {2'b00, activePower});
      rdchk(`AWSS_ADDR_EVENT_STATUS, 8'h03, "flag on sleep");
      rdchk(`AWSS_ADDR_SYSTEM_STATE, 8'h01, "state sleep");
      rdchk(`AWSS_ADDR_EVENT_STATUS, 8'h01, "flag cleared");
      set_event(1'b1);
      check("woken", 16'h0000, {15'h0000, asleep});
      check("wake power", {2'b00, wakeExp}, {2'b00, activePower});
      rdchk(`AWSS_ADDR_EVENT_STATUS, 8'h03, "flag on wake");
      rdchk(`AWSS_ADDR_SYSTEM_STATE, 8'h00, "state wake");
      set_event(1'b0);
      $display("test sleep cycle %0d done", f);
    end
    host_u.wr(`AWSS_ADDR_IRQ_ENABLE, 8'h00);
    tick(3);
    check("asleep flag off", 16'h0001, {15'h0000, asleep});
    rdchk(`AWSS_ADDR_EVENT_STATUS, 8'h01, "flag disabled");
    // a zero count written while asleep turns the function off and returns to wake
    host_u.wr(`AWSS_ADDR_INACT_LOW, 8'h00);
    @(negedge clock);
    check("count zero wakes", 16'h0000, {15'h0000, asleep});
    host_u.wr(`AWSS_ADDR_IRQ_ENABLE, 8'h02);
    tick(5);
    check("count zero awake", 16'h0000, {15'h0000, asleep});
    rdchk(`AWSS_ADDR_EVENT_STATUS, 8'h01, "count zero flag");
    $display("test disable done");
    for (int k = 0; k < 2; k++) begin
      @(negedge clock);
      softReset = (k == 0);
      hibernateExit = (k == 1);
      @(negedge clock);
      softReset = 1'b0;
      hibernateExit = 1'b0;
      rdchk(`AWSS_ADDR_EVENT_STATUS, 8'h00, "status restart");
      boot();
      rdchk(`AWSS_ADDR_EVENT_STATUS, 8'h01, "status reboot");
    end
    $display("test restart done");
    close_out();
  end
endmodule
